// file: src/hwto_top.sv
// Haptic library waveform time-offset stage: registers, segment store and playback
`timescale 1ns/10ps
`include "hwto_map.svh"
module hwto_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic openLoop,
    input wire logic stepPeriodSelect,
    input wire logic inValid,
    input wire hwto_pkg::hwto_seg_t inSeg,
    output logic inReady,
    output logic outValid,
    output hwto_pkg::hwto_seg_t outSeg,
    input wire logic outReady
);
    import hwto_pkg::*;

    logic signed [7:0] overdriveTimeAdjust;
    logic signed [7:0] positiveSustainTimeAdjust;
    logic signed [7:0] negativeSustainTimeAdjust;
    logic signed [7:0] next_overdriveTimeAdjust;
    logic signed [7:0] next_positiveSustainTimeAdjust;
    logic signed [7:0] next_negativeSustainTimeAdjust;
    logic [7:0] next_regRdData;

    hwto_state_t state;
    hwto_state_t next_state;
    hwto_seg_t mem [`HWTO_DEPTH];
    hwto_seg_t next_mem [`HWTO_DEPTH];
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [3:0] rdIdx;
    logic [3:0] next_rdIdx;
    logic [2:0] peakIdx;
    logic [2:0] next_peakIdx;
    logic signed [7:0] peakAmp;
    logic signed [7:0] next_peakAmp;
    logic next_inReady;
    logic next_outValid;
    hwto_seg_t next_outSeg;

    // Checking aids that travel with each emitted segment
    hwto_cls_t outCls;
    hwto_cls_t next_outCls;
    logic [15:0] outRaw;
    logic [15:0] next_outRaw;
    logic signed [7:0] outOff;
    logic signed [7:0] next_outOff;
    logic [2:0] outStep;
    logic [2:0] next_outStep;

    hwto_seg_t curSeg;
    hwto_cls_t curCls;
    logic signed [7:0] curOff;
    logic curApply;
    logic [2:0] stepMs;
    logic [15:0] adjDur;

    // Register file, reached at the documented offsets
    always_comb
    begin
        next_overdriveTimeAdjust = overdriveTimeAdjust;
        next_positiveSustainTimeAdjust = positiveSustainTimeAdjust;
        next_negativeSustainTimeAdjust = negativeSustainTimeAdjust;
        next_regRdData = regRdData;
        if (regWrEn)
        begin
            unique case (regAddr)
                `HWTO_ADDR_OVERDRIVE: next_overdriveTimeAdjust = regWrData;
                `HWTO_ADDR_POS_SUSTAIN: next_positiveSustainTimeAdjust = regWrData;
                `HWTO_ADDR_NEG_SUSTAIN: next_negativeSustainTimeAdjust = regWrData;
                default: ;
            endcase
        end
        if (regRdEn)
        begin
            unique case (regAddr)
                `HWTO_ADDR_OVERDRIVE: next_regRdData = overdriveTimeAdjust;
                `HWTO_ADDR_POS_SUSTAIN: next_regRdData = positiveSustainTimeAdjust;
                `HWTO_ADDR_NEG_SUSTAIN: next_regRdData = negativeSustainTimeAdjust;
                default: next_regRdData = `HWTO_RST_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            overdriveTimeAdjust <= `HWTO_RST_ADJUST;
            positiveSustainTimeAdjust <= `HWTO_RST_ADJUST;
            negativeSustainTimeAdjust <= `HWTO_RST_ADJUST;
            regRdData <= `HWTO_RST_DATA;
        end
        else
        begin
            overdriveTimeAdjust <= next_overdriveTimeAdjust;
            positiveSustainTimeAdjust <= next_positiveSustainTimeAdjust;
            negativeSustainTimeAdjust <= next_negativeSustainTimeAdjust;
            regRdData <= next_regRdData;
        end
    end

    // Classification of the entry about to be emitted
    always_comb
    begin
        curSeg = mem[rdIdx[2:0]];
        stepMs = stepPeriodSelect ? `HWTO_STEP_MS_FAST : `HWTO_STEP_MS_SLOW;
        curCls = HWTO_CLS_NONE;
        curOff = '0;
        curApply = 1'b0;
        // A waveform whose peak is not positive has no overdrive part
        if (rdIdx[2:0] == peakIdx && peakAmp > 0)
        begin
            curCls = HWTO_CLS_OD;
            curOff = overdriveTimeAdjust;
            curApply = openLoop;
        end
        else if (curSeg.amp > 0)
        begin
            curCls = HWTO_CLS_POS;
            curOff = positiveSustainTimeAdjust;
            curApply = 1'b1;
        end
        else if (curSeg.amp < 0)
        begin
            curCls = HWTO_CLS_NEG;
            curOff = negativeSustainTimeAdjust;
            curApply = 1'b1;
        end
    end

    hwto_seg_adjust uAdjust (
        .durMs(curSeg.durMs),
        .offset(curOff),
        .stepMs(stepMs),
        .applyEn(curApply),
        .adjMs(adjDur)
    );

    // Whole waveform is stored first, since the peak is known only at its end
    always_comb
    begin
        next_state = state;
        next_mem = mem;
        next_cnt = cnt;
        next_rdIdx = rdIdx;
        next_peakIdx = peakIdx;
        next_peakAmp = peakAmp;
        next_outValid = outValid;
        next_outSeg = outSeg;
        next_outCls = outCls;
        next_outRaw = outRaw;
        next_outOff = outOff;
        next_outStep = outStep;
        unique case (state)
            HWTO_LOAD:
            begin
                if (inValid && inReady)
                begin
                    next_mem[cnt[2:0]] = inSeg;
                    next_cnt = cnt + 4'h1;
                    if (cnt == 4'h0 || inSeg.amp > peakAmp)
                    begin
                        next_peakAmp = inSeg.amp;
                        next_peakIdx = cnt[2:0];
                    end
                    if (inSeg.last || cnt[2:0] == `HWTO_LAST_IDX)
                    begin
                        next_state = HWTO_PLAY;
                        next_rdIdx = 4'h0;
                    end
                end
            end
            HWTO_PLAY:
            begin
                if (outValid && outReady)
                begin
                    next_outValid = 1'b0;
                    if (outSeg.last)
                    begin
                        next_state = HWTO_LOAD;
                        next_cnt = 4'h0;
                    end
                end
                if ((!outValid || outReady) && rdIdx < cnt)
                begin
                    next_outValid = 1'b1;
                    next_outSeg.amp = curSeg.amp;
                    next_outSeg.durMs = adjDur;
                    next_outSeg.last = (rdIdx + 4'h1 == cnt);
                    next_outCls = curCls;
                    next_outRaw = curSeg.durMs;
                    next_outOff = curApply ? curOff : 8'sh00;
                    next_outStep = stepMs;
                    next_rdIdx = rdIdx + 4'h1;
                end
            end
        endcase
        next_inReady = (next_state == HWTO_LOAD);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= HWTO_LOAD;
            for (int i = 0; i < `HWTO_DEPTH; i++)
            begin
                mem[i] <= '0;
            end
            cnt <= 4'h0;
            rdIdx <= 4'h0;
            peakIdx <= 3'h0;
            peakAmp <= 8'sh00;
            inReady <= 1'b0;
            outValid <= 1'b0;
            outSeg <= '0;
            outCls <= HWTO_CLS_NONE;
            outRaw <= 16'h0000;
            outOff <= 8'sh00;
            outStep <= 3'h0;
        end
        else
        begin
            state <= next_state;
            mem <= next_mem;
            cnt <= next_cnt;
            rdIdx <= next_rdIdx;
            peakIdx <= next_peakIdx;
            peakAmp <= next_peakAmp;
            inReady <= next_inReady;
            outValid <= next_outValid;
            outSeg <= next_outSeg;
            outCls <= next_outCls;
            outRaw <= next_outRaw;
            outOff <= next_outOff;
            outStep <= next_outStep;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    AST_RD_OVERDRIVE: assert property (
        regRdEn && regAddr == `HWTO_ADDR_OVERDRIVE |=> regRdData == $past(overdriveTimeAdjust))
        else $error("overdrive offset readback wrong");
    AST_WR_POS: assert property (
        regWrEn && regAddr == `HWTO_ADDR_POS_SUSTAIN
        |=> positiveSustainTimeAdjust == $past(regWrData))
        else $error("positive sustain offset not stored");
    AST_WR_NEG: assert property (
        regWrEn && regAddr == `HWTO_ADDR_NEG_SUSTAIN
        |=> negativeSustainTimeAdjust == $past(regWrData))
        else $error("negative sustain offset not stored");
    AST_PEAK: assert property (
        outValid && outCls == HWTO_CLS_OD |-> outSeg.amp == peakAmp && peakAmp > 0)
        else $error("overdrive segment is not the peak");
    AST_LOAD_END: assert property (
        inValid && inReady && inSeg.last |=> state == HWTO_PLAY && !inReady)
        else $error("last segment did not start playback");
    // Checked at the emitting edge, so openLoop is taken from the cycle in which the entry is classified
    AST_CLOSED: assert property (
        state == HWTO_PLAY && (!outValid || outReady) && rdIdx < cnt
        && curCls == HWTO_CLS_OD && !openLoop
        |=> outOff == 8'sh00 && outSeg.durMs == outRaw)
        else $error("overdrive adjusted in closed loop");
    AST_CLASS_POS: assert property (
        outValid && outSeg.amp > 0 && outCls != HWTO_CLS_OD |-> outCls == HWTO_CLS_POS)
        else $error("positive entry misclassified");
    AST_CLASS_NEG: assert property (
        outValid && outSeg.amp < 0 |-> outCls == HWTO_CLS_NEG)
        else $error("negative entry misclassified");
    AST_SHORTEN: assert property (
        outValid && outOff < 0 && outRaw != 16'h0000 |-> outSeg.durMs < outRaw)
        else $error("negative offset did not shorten");
    AST_EXACT: assert property (
        outValid && outRaw >= 16'h03e8 && outRaw <= 16'hea60
        |-> int'(outSeg.durMs) - int'(outRaw) == int'(outOff) * int'(outStep))
        else $error("adjustment differs from offset times interval");
    AST_CLAMP: assert property (
        outValid && int'(outRaw) + int'(outOff) * int'(outStep) < 0 |-> outSeg.durMs == 16'h0000)
        else $error("adjusted duration not clamped at zero");

    COV_OD_OPEN: cover property (outValid && outReady && outCls == HWTO_CLS_OD && outOff != 0);
    COV_NEG: cover property (outValid && outReady && outCls == HWTO_CLS_NEG && outOff != 0);
    COV_FULL: cover property (inValid && inReady && cnt == 4'h7 ##1 state == HWTO_PLAY);

endmodule : hwto_top

// file: src/hwto_map.svh
// Register offsets, reset values and timing constants of the waveform time-offset stage
`ifndef HWTO_MAP_SVH
`define HWTO_MAP_SVH

`define HWTO_ADDR_OVERDRIVE 8'h0d
`define HWTO_ADDR_POS_SUSTAIN 8'h0e
`define HWTO_ADDR_NEG_SUSTAIN 8'h0f
`define HWTO_RST_ADJUST 8'h00
`define HWTO_RST_DATA 8'h00
`define HWTO_DEPTH 4'h8
`define HWTO_LAST_IDX 3'h7
`define HWTO_STEP_MS_SLOW 3'h5
`define HWTO_STEP_MS_FAST 3'h1
`define HWTO_DUR_MAX 16'hffff

`endif

// file: src/hwto_pkg.sv
// Types shared by the waveform time-offset stage
package hwto_pkg;

    typedef struct packed {
        logic signed [7:0] amp;
        logic [15:0] durMs;
        logic last;
    } hwto_seg_t;

    typedef enum logic [1:0] {
        HWTO_LOAD = 2'b01,
        HWTO_PLAY = 2'b10
    } hwto_state_t;

    typedef enum logic [1:0] {
        HWTO_CLS_NONE = 2'h0,
        HWTO_CLS_OD = 2'h1,
        HWTO_CLS_POS = 2'h2,
        HWTO_CLS_NEG = 2'h3
    } hwto_cls_t;

endpackage : hwto_pkg

// file: src/hwto_seg_adjust.sv
// Signed duration adjustment of one waveform segment with clamping
`timescale 1ns/10ps
module hwto_seg_adjust (
    input wire logic [15:0] durMs,
    input wire logic signed [7:0] offset,
    input wire logic [2:0] stepMs,
    input wire logic applyEn,
    output logic [15:0] adjMs
);
    logic signed [11:0] delta;
    logic signed [17:0] sum;

    always_comb
    begin
        delta = '0;
        if (applyEn)
        begin
            // Offset times step period, signed in milliseconds
            delta = $signed(12'(offset)) * $signed(12'({1'b0, stepMs}));
        end
        sum = $signed({2'b00, durMs}) + $signed(18'(delta));
        // Clamp at zero; top clamp avoids wrap on long segments
        if (sum < 0)
        begin
            adjMs = '0;
        end
        else if (sum > $signed({2'b00, `HWTO_DUR_MAX}))
        begin
            adjMs = `HWTO_DUR_MAX;
        end
        else
        begin
            adjMs = sum[15:0];
        end
    end

endmodule : hwto_seg_adjust

// file: bench/hwto_top_tb_top.sv
// Self-checking bench of the waveform time-offset stage with a queue-based reference model
`timescale 1ns/10ps
`include "hwto_map.svh"
module hwto_top_tb_top;
    import hwto_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic openLoop = 1'b0;
    logic stepPeriodSelect = 1'b0;
    logic inValid = 1'b0;
    hwto_seg_t inSeg = '0;
    logic inReady;
    logic outValid;
    hwto_seg_t outSeg;
    logic outReady = 1'b0;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] lfsr = 32'hb7e4;
    logic signed [7:0] shadow [3] = '{8'sh00, 8'sh00, 8'sh00};
    logic [31:0] r;

    always #10 mclk = ~mclk;

    hwto_top hwto_top_i (
        .mclk(mclk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .openLoop(openLoop),
        .stepPeriodSelect(stepPeriodSelect), .inValid(inValid), .inSeg(inSeg),
        .inReady(inReady), .outValid(outValid), .outSeg(outSeg), .outReady(outReady)
    );

    function automatic logic [31:0] nextRand();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h80200003 : 32'h0);
        return lfsr;
    endfunction : nextRand

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic checkByte(input string what, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : checkByte

    task automatic checkSeg(input hwto_seg_t e, input hwto_seg_t g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR outSeg expected %h seen %h", e, g);
        end
    endtask : checkSeg

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge mclk);
        regWrEn = 1'b0;
        if (a >= `HWTO_ADDR_OVERDRIVE && a <= `HWTO_ADDR_NEG_SUSTAIN)
            shadow[a - `HWTO_ADDR_OVERDRIVE] = d;
    endtask : regWrite

    task automatic regRead(input logic [7:0] a);
        logic [7:0] e;
        e = 8'h00;
        if (a >= `HWTO_ADDR_OVERDRIVE && a <= `HWTO_ADDR_NEG_SUSTAIN)
            e = shadow[a - `HWTO_ADDR_OVERDRIVE];
        @(negedge mclk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge mclk);
        regRdEn = 1'b0;
        checkByte("regRdData", e, regRdData);
    endtask : regRead

    // Interval and loop mode stay put for a whole waveform, since they are sampled per entry
    task automatic runWave(input int n, input logic ol, input logic sp);
        hwto_seg_t q[$];
        hwto_seg_t s;
        hwto_seg_t e;
        int odIdx;
        int maxAmp;
        int off;
        int d;
        int got;
        int guard;
        odIdx = -1;
        maxAmp = -129;
        for (int i = 0; i < n; i++)
        begin
            r = nextRand();
            s.amp = {r[3:0], 4'h0};
            // Short, mid-range and near-full durations reach both clamps and the exact path
            s.durMs = r[8] ? {8'h00, r[23:16]} : (r[9] ? {8'h10, r[23:16]} : {8'hff, r[23:16]});
            s.last = (i == n - 1);
            q.push_back(s);
            if (int'(s.amp) > maxAmp)
            begin
                maxAmp = int'(s.amp);
                odIdx = i;
            end
        end
        if (maxAmp <= 0)
            odIdx = -1;
        @(negedge mclk);
        openLoop = ol;
        stepPeriodSelect = sp;
        for (int i = 0; i < n; i++)
        begin
            inValid = 1'b1;
            inSeg = q[i];
            guard = 0;
            while (inReady !== 1'b1 && guard < 50)
            begin
                @(negedge mclk);
                guard++;
            end
            if (guard >= 50)
            begin
                errors++;
                $display("ERROR inReady expected 1 seen %b", inReady);
            end
            @(negedge mclk);
        end
        inValid = 1'b0;
        got = 0;
        guard = 0;
        while (got < n && guard < 300)
        begin
            r = nextRand();
            outReady = r[0] | r[1];
            if (outValid === 1'b1 && outReady)
            begin
                e = q[got];
                off = 0;
                if (got == odIdx)
                    off = ol ? int'(shadow[0]) : 0;
                else if (e.amp > 0)
                    off = int'(shadow[1]);
                else if (e.amp < 0)
                    off = int'(shadow[2]);
                d = int'(e.durMs) + off * (sp ? 1 : 5);
                d = (d < 0) ? 0 : ((d > 65535) ? 65535 : d);
                e.durMs = d[15:0];
                checkSeg(e, outSeg);
                got++;
            end
            guard++;
            @(negedge mclk);
        end
        outReady = 1'b0;
        checkByte("outputCount", 8'(n), 8'(got));
    endtask : runWave

    // Hang guard; a normal run needs under a thousand cycles
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors++;
            $display("ERROR cycles expected below 40000 seen %0d", cycles);
            conclude();
        end
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        for (int a = 8'h0c; a <= 8'h10; a++)
            regRead(8'(a));
        regWrite(8'h10, 8'h5a);
        regRead(8'h10);
        for (int k = 0; k < 32; k++)
        begin
            r = nextRand();
            if (k % 4 == 0)
            begin
                regWrite(`HWTO_ADDR_OVERDRIVE, (k % 8 == 0) ? 8'h80 : r[7:0]);
                regWrite(`HWTO_ADDR_POS_SUSTAIN, (k % 8 == 4) ? 8'h7f : r[15:8]);
                regWrite(`HWTO_ADDR_NEG_SUSTAIN, (k % 16 == 0) ? 8'hff : r[23:16]);
                regRead(`HWTO_ADDR_OVERDRIVE);
                regRead(`HWTO_ADDR_POS_SUSTAIN);
                regRead(`HWTO_ADDR_NEG_SUSTAIN);
            end
            runWave((k % 8 == 0) ? 8 : ((k % 8 == 1) ? 1 : 1 + int'(r[26:24])), r[28], r[29]);
        end
        // Second reset in mid-run must bring every offset back to zero
        @(negedge mclk);
        rstn = 1'b0;
        shadow = '{8'sh00, 8'sh00, 8'sh00};
        @(negedge mclk);
        rstn = 1'b1;
        regRead(`HWTO_ADDR_OVERDRIVE);
        regRead(`HWTO_ADDR_POS_SUSTAIN);
        regRead(`HWTO_ADDR_NEG_SUSTAIN);
        runWave(5, 1'b1, 1'b0);
        conclude();
    end
endmodule : hwto_top_tb_top
